//--- rtl/pll_ctrl_pkg.sv
// Purpose : shared constants and carriers for the pll control register bank
// Assumes : mclk at 200 MHz
// Notes   : register offsets are five-bit serial-port addresses
`default_nettype none
package pll_ctrl_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [4:0] REG_IDENTITY      = 5'h00;
   localparam logic [4:0] REG_POWER         = 5'h01;
   localparam logic [4:0] REG_VCO_PACKET    = 5'h05;
   localparam logic [23:0] POWER_RESET      = 24'h000002;
   localparam logic [15:0] PACKET_RESET     = 16'h0000;
   localparam logic [4:0] READ_PTR_RESET    = 5'h00;
   localparam int          READ_PTR_MSB     = 4;
   localparam int          SOFT_RESET_BIT   = 5;
   localparam int          PIN_SELECT_BIT   = 0;
   localparam int          REG_ENABLE_BIT   = 1;
   localparam int          HOLD_LSB         = 2;
   localparam int          HOLD_MSB         = 7;
   localparam int          POWER_MSB        = 9;
   // ----------------------------------------------------------------
   // internal vco serial link
   // ----------------------------------------------------------------
   localparam int          PACKET_BITS      = 16;
   localparam int          RATE_FIELD_LSB   = 13;
   localparam int          RATE_FIELD_MSB   = 14;
   localparam int          MCLK_MHZ         = 200;
   localparam int          FSM_CLK_MAX_MHZ  = 50;
   // least divide ratio, rounded up so the link never beats its limit
   localparam int          LINK_MIN_DIV     = (MCLK_MHZ + FSM_CLK_MAX_MHZ - 1) / FSM_CLK_MAX_MHZ;
   localparam logic [2:0]  TARGET_SUBSYSTEM = 3'h0;
   localparam logic [3:0]  CAL_TARGET_INDEX = 4'h0;

   typedef struct packed {
      logic [8:0] subsystemPayload;
      logic [3:0] subsystemRegisterIndex;
      logic [2:0] subsystemIdentifier;
   } vco_packet_s;

   typedef struct packed {
      logic biasGenerators;
      logic phaseDetector;
      logic chargePump;
      logic referenceBuffer;
      logic dividerBuffer;
      logic outputDriver;
   } power_domains_s;
endpackage
`default_nettype wire

//--- rtl/vco_link_serializer.sv
// Purpose : shifts one 16-bit packet msb first onto the internal vco link
// Assumes : start is only honoured while idle
// Notes   : link clock idles low, data changes while the clock is low
`default_nettype none
module vco_link_serializer
#(
   parameter int WIDTH = pll_ctrl_pkg::PACKET_BITS
)
(
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic [1:0]       rateSel,
   input  wire logic             start,
   input  wire logic [WIDTH-1:0] packet,
   output logic                  busy,
   output logic                  linkClk,
   output logic                  linkData,
   output logic                  linkFrame
);
   typedef enum logic [0:0] {IDLE = 1'b0, SHIFT = 1'b1} link_state_e;

   // ----------------------------------------------------------------
   // divider: bit period of LINK_MIN_DIV << rateSel mclk cycles
   // ----------------------------------------------------------------
   function automatic logic [7:0] halfPeriod(input logic [1:0] sel);
      halfPeriod = 8'((pll_ctrl_pkg::LINK_MIN_DIV / 2) << sel);
   endfunction

   link_state_e      state_q, state_d;
   logic [WIDTH-1:0] shift_q, shift_d;
   logic [4:0]       bitsLeft_q, bitsLeft_d;
   logic [7:0]       div_q, div_d;
   logic [1:0]       rate_q, rate_d;
   logic             clk_q, clk_d;

   always_comb
   begin
      state_d    = state_q;
      shift_d    = shift_q;
      bitsLeft_d = bitsLeft_q;
      div_d      = div_q;
      rate_d     = rate_q;
      clk_d      = clk_q;
      case (state_q)
         IDLE:
         begin
            clk_d = 1'b0;
            if (start)
            begin
               state_d    = SHIFT;
               shift_d    = packet;
               bitsLeft_d = 5'(WIDTH);
               rate_d     = rateSel;
               div_d      = halfPeriod(rateSel) - 8'h01;
            end
         end
         SHIFT:
         begin
            // one packet bit per link clock cycle [R21]
            if (div_q == 8'h00)
            begin
               div_d = halfPeriod(rate_q) - 8'h01;
               clk_d = ~clk_q;
               if (clk_q)
               begin
                  shift_d    = {shift_q[WIDTH-2:0], 1'b0}; // msb first [R4]
                  bitsLeft_d = bitsLeft_q - 5'h01;
                  if (bitsLeft_q == 5'h01)
                  begin
                     state_d = IDLE; // whole packet out before the next [R21]
                  end
               end
            end
            else
            begin
               div_d = div_q - 8'h01;
            end
         end
         default:
         begin
            state_d = IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q    <= IDLE;
         shift_q    <= '0;
         bitsLeft_q <= 5'h00;
         div_q      <= 8'h00;
         rate_q     <= 2'h0;
         clk_q      <= 1'b0;
      end
      else
      begin
         state_q    <= state_d;
         shift_q    <= shift_d;
         bitsLeft_q <= bitsLeft_d;
         div_q      <= div_d;
         rate_q     <= rate_d;
         clk_q      <= clk_d;
      end
   end

   assign busy      = (state_q == SHIFT);
   assign linkClk   = clk_q;
   assign linkData  = shift_q[WIDTH-1];
   assign linkFrame = (state_q == SHIFT);
endmodule
`default_nettype wire

//--- rtl/pll_control_regs_vco_forwarder.sv
// Purpose : front-end control registers and forwarder to the vco subsystem
// Assumes : serial-port framing lives outside and presents parallel accesses
// Notes   : one packet can wait while another is on the link
//
// Contract
// R1 - vco subsystem is reached over an internal 16-bit packet link
// R2 - link runs from the calibration fsm clock, never above 50 MHz
// R3 - link clock rate comes from bits 14:13 of register 0Ah
// R4 - each write to the indirect register is sent msb first; a write arriving while one already waits replaces the waiting packet
// R5 - packet fields: identifier 2:0, index 6:3, payload 15:7
// R6 - subsystem answers identifier zero; packets must carry zero there
// R7 - calibration overwrites only the payload; index must be zero
// R8 - host restores index zero after manual access before recalibration
// R9 - reading the indirect register returns only the last sent packet
// R10 - before manual vco reset, host copies switch bits into packet 15:8
// R11 - manual reset packet: select, dont-care, caps, zero, zero index, zero id
// R12 - register 00h reads a fixed 24-bit identification code
// R13 - write to 00h stores bits 4:0 as next read address
// R14 - bit 5 written to 00h soft-resets both serial variants
// R15 - host writes zeros into bits 23:6 of register 00h
// R16 - power bit 0 selects chip-enable pin or register enable bit
// R17 - power bit 1 is the register enable, resetting to one
// R18 - bits 2..7 keep one circuit each powered while disabled
// R19 - host follows the documented start-up configuration order
// R20 - host retunes with integer and fractional writes only
// R21 - one bit per link clock; a transfer ends before the next starts
`default_nettype none
module pll_control_regs_vco_forwarder
#(
   // arbitrary value; the real identification code is not reproduced
   parameter logic [23:0] DEVICE_IDENTIFIER = 24'h5A5A01
)
(
   input  wire logic                        mclk,
   input  wire logic                        rst_n,
   input  wire logic                        regWrite,
   input  wire logic                        regRead,
   input  wire logic [4:0]                  regAddr,
   input  wire logic [23:0]                 regWdata,
   output logic      [23:0]                 regRdata,
   output logic      [4:0]                  readPointer,
   output logic                             softReset,
   input  wire logic [23:0]                 configWord0A,
   input  wire logic                        calPayloadWrite,
   input  wire logic [8:0]                  calPayload,
   input  wire logic                        chipEnablePin,
   output logic                             synthEnable,
   output pll_ctrl_pkg::power_domains_s     powerOn,
   output logic                             vcoLinkClk,
   output logic                             vcoLinkData,
   output logic                             vcoLinkFrame,
   output logic                             vcoLinkBusy
);
   // ----------------------------------------------------------------
   // chip-enable pin synchroniser
   // ----------------------------------------------------------------
   logic chipEnMeta_q;
   logic chipEnSync_q;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         chipEnMeta_q <= 1'b0;
         chipEnSync_q <= 1'b0;
      end
      else
      begin
         chipEnMeta_q <= chipEnablePin;
         chipEnSync_q <= chipEnMeta_q;
      end
   end

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [4:0]                readPtr_q, readPtr_d;
   logic                      softRst_q, softRst_d;
   logic [23:0]               power_q, power_d;
   pll_ctrl_pkg::vco_packet_s packet_q, packet_d;
   pll_ctrl_pkg::vco_packet_s lastSent_q, lastSent_d;
   logic                      pending_q, pending_d;
   logic [23:0]               rdata_q, rdata_d;
   logic                      linkBusy;
   logic                      launch;

   function automatic logic hit(input logic [4:0] addr, input logic [4:0] reg_offset);
      hit = (addr == reg_offset);
   endfunction

   // a transfer starts only when the link is idle
   assign launch = pending_q & ~linkBusy; // [R21]

   always_comb
   begin
      readPtr_d  = readPtr_q;
      softRst_d  = 1'b0;
      power_d    = power_q;
      packet_d   = packet_q;
      lastSent_d = lastSent_q;
      pending_d  = pending_q;
      rdata_d    = rdata_q;

      if (launch)
      begin
         pending_d  = 1'b0;
         lastSent_d = packet_q; // readback mirrors the transfer [R9]
      end

      if (regWrite && hit(regAddr, pll_ctrl_pkg::REG_IDENTITY))
      begin
         readPtr_d = regWdata[pll_ctrl_pkg::READ_PTR_MSB:0]; // [R13]
         if (regWdata[pll_ctrl_pkg::SOFT_RESET_BIT])
         begin
            softRst_d = 1'b1; // [R14]
            readPtr_d = pll_ctrl_pkg::READ_PTR_RESET;
         end
      end

      if (regWrite && hit(regAddr, pll_ctrl_pkg::REG_POWER))
      begin
         power_d = {14'h0000, regWdata[pll_ctrl_pkg::POWER_MSB:0]}; // [R16] [R17] [R18]
      end

      // a host write queues a transfer, and so does a calibration update unless a host write to 05h comes in the same cycle;
      // the set wins over the launch clear in the same cycle
      if (regWrite && hit(regAddr, pll_ctrl_pkg::REG_VCO_PACKET))
      begin
         packet_d  = pll_ctrl_pkg::vco_packet_s'(regWdata[pll_ctrl_pkg::PACKET_BITS-1:0]); // [R4] [R5]
         pending_d = 1'b1; // [R4]
      end
      else if (calPayloadWrite)
      begin
         // identifier and index are left as the host set them [R6] [R7]
         packet_d.subsystemPayload = calPayload; // [R7]
         pending_d                 = 1'b1;
      end

      if (regRead)
      begin
         case (regAddr)
            pll_ctrl_pkg::REG_IDENTITY:   rdata_d = DEVICE_IDENTIFIER; // [R12]
            pll_ctrl_pkg::REG_POWER:      rdata_d = power_q;
            pll_ctrl_pkg::REG_VCO_PACKET: rdata_d = {8'h00, lastSent_q}; // [R9]
            default:                      rdata_d = 24'h000000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         readPtr_q  <= pll_ctrl_pkg::READ_PTR_RESET;
         softRst_q  <= 1'b0;
         power_q    <= pll_ctrl_pkg::POWER_RESET; // [R17]
         packet_q   <= pll_ctrl_pkg::PACKET_RESET;
         lastSent_q <= pll_ctrl_pkg::PACKET_RESET;
         pending_q  <= 1'b0;
         rdata_q    <= 24'h000000;
      end
      else
      begin
         readPtr_q  <= readPtr_d;
         softRst_q  <= softRst_d;
         power_q    <= power_d;
         packet_q   <= packet_d;
         lastSent_q <= lastSent_d;
         pending_q  <= pending_d;
         rdata_q    <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // power control
   // ----------------------------------------------------------------
   logic enableNow;
   logic [5:0] holdBits;

   // pin or register bit as the enable source [R16]
   assign enableNow = power_q[pll_ctrl_pkg::PIN_SELECT_BIT] ? chipEnSync_q
                                                            : power_q[pll_ctrl_pkg::REG_ENABLE_BIT]; // [R16] [R17]
   assign holdBits  = power_q[pll_ctrl_pkg::HOLD_MSB:pll_ctrl_pkg::HOLD_LSB];

   // each hold bit overrides a disabled enable for its own circuit
   assign powerOn.biasGenerators  = enableNow | holdBits[0]; // [R18]
   assign powerOn.phaseDetector   = enableNow | holdBits[1]; // [R18]
   assign powerOn.chargePump      = enableNow | holdBits[2]; // [R18]
   assign powerOn.referenceBuffer = enableNow | holdBits[3]; // [R18]
   assign powerOn.dividerBuffer   = enableNow | holdBits[4]; // [R18]
   assign powerOn.outputDriver    = enableNow | holdBits[5]; // [R18]
   assign synthEnable             = enableNow;

   // ----------------------------------------------------------------
   // internal vco link
   // ----------------------------------------------------------------
   // rate field of the calibration configuration word sets the divide [R2] [R3]
   vco_link_serializer
   #(
      .WIDTH (pll_ctrl_pkg::PACKET_BITS)
   )
   u_link
   (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .rateSel   (configWord0A[pll_ctrl_pkg::RATE_FIELD_MSB:pll_ctrl_pkg::RATE_FIELD_LSB]), // [R3]
      .start     (launch), // [R1]
      .packet    (packet_q),
      .busy      (linkBusy),
      .linkClk   (vcoLinkClk),
      .linkData  (vcoLinkData),
      .linkFrame (vcoLinkFrame)
   );

   assign regRdata    = rdata_q;
   assign readPointer = readPtr_q;
   assign softReset   = softRst_q;
   // busy covers a queued packet too, so software sees the whole backlog
   assign vcoLinkBusy = linkBusy | pending_q;
endmodule
`default_nettype wire

//--- testbench/pll_control_regs_properties.sv
// Purpose: port-level checks of the pll control bank
// Assumes: one clock, rst_n async active low
// Notes: shadows reg01 and the link rate locally
`default_nettype none
module pll_control_regs_properties
#(
   parameter logic [23:0] DEVICE_IDENTIFIER = 24'h5A5A01
)
(
   input wire logic                          mclk,
   input wire logic                          rst_n,
   input wire logic                          regWrite,
   input wire logic                          regRead,
   input wire logic [4:0]                    regAddr,
   input wire logic [23:0]                   regWdata,
   input wire logic [23:0]                   regRdata,
   input wire logic [4:0]                    readPointer,
   input wire logic                          softReset,
   input wire logic [23:0]                   configWord0A,
   input wire logic                          synthEnable,
   input wire pll_ctrl_pkg::power_domains_s  powerOn,
   input wire logic                          vcoLinkClk,
   input wire logic                          vcoLinkFrame,
   input wire logic                          vcoLinkBusy
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----
   // helper logic
   // ----
   logic [9:0] pwr_q, pwr_d, cnt_q, cnt_d;
   logic [1:0] rate_q, rate_d;
   // rate is frozen at launch, so only an idle link may reload it
   always_comb
   begin
      pwr_d = (regWrite && regAddr == 5'h01) ? regWdata[9:0] : pwr_q;
      cnt_d = vcoLinkFrame ? cnt_q + 10'h001 : 10'h000;
      rate_d = vcoLinkFrame ? rate_q : configWord0A[14:13];
   end
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pwr_q <= 10'h002;
         cnt_q <= 10'h000;
         rate_q <= 2'h0;
      end
      else
      begin
         pwr_q <= pwr_d;
         cnt_q <= cnt_d;
         rate_q <= rate_d;
      end
   end
   // ----
   // assertions
   // ----
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_soft_reset_pulse: assert property (
      regWrite && regAddr == 5'h00 && regWdata[5] |=> softReset) else $error("soft reset pulse missing");
   a_read_pointer_load: assert property (
      regWrite && regAddr == 5'h00 && !regWdata[5] |=> readPointer == $past(regWdata[4:0]))
      else $error("read pointer not stored");
   a_identity_read: assert property (
      regRead && regAddr == 5'h00 |=> regRdata == DEVICE_IDENTIFIER) else $error("identity read wrong");
   a_enable_source: assert property (
      !pwr_q[0] |-> synthEnable == pwr_q[1]) else $error("register enable not followed");
   a_hold_domains: assert property (
      powerOn == ({6{synthEnable}} | {pwr_q[2], pwr_q[3], pwr_q[4], pwr_q[5], pwr_q[6], pwr_q[7]}))
      else $error("power domain wrong");
   a_frame_length: assert property (
      $fell(vcoLinkFrame) |-> cnt_q == (10'h040 << rate_q)) else $error("frame length wrong");
   a_link_clock_idle: assert property (
      !vcoLinkFrame |-> !vcoLinkClk) else $error("link clock runs outside frame");
   a_link_clock_rate: assert property (
      $rose(vcoLinkClk) |=> vcoLinkClk) else $error("link clock above limit");
   a_packet_queued: assert property (
      regWrite && regAddr == 5'h05 |=> vcoLinkBusy) else $error("write not forwarded");
endmodule
bind pll_control_regs_vco_forwarder pll_control_regs_properties #(.DEVICE_IDENTIFIER(DEVICE_IDENTIFIER)) props
   (.mclk(mclk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .readPointer(readPointer), .softReset(softReset),
    .configWord0A(configWord0A), .synthEnable(synthEnable), .powerOn(powerOn),
    .vcoLinkClk(vcoLinkClk), .vcoLinkFrame(vcoLinkFrame), .vcoLinkBusy(vcoLinkBusy));
`default_nettype wire

//--- testbench/vco_link_receiver.sv
// Purpose: far-side model of the vco subsystem link
// Assumes: data is stable at the rising link clock
// Notes: latches a packet when the frame drops
`default_nettype none
module vco_link_receiver
(
   input wire logic                     mclk,
   input wire logic                     rst_n,
   input wire logic                     linkClk,
   input wire logic                     linkData,
   input wire logic                     linkFrame,
   output pll_ctrl_pkg::vco_packet_s    rxPacket,
   output logic [4:0]                   rxBits,
   output int                           rxCount
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] shift_q;
   logic [4:0]  bits_q;
   logic        clkPrev_q, framePrev_q;
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {shift_q, bits_q, clkPrev_q, framePrev_q, rxPacket, rxBits} <= '0;
         rxCount <= 0;
      end
      else
      begin
         clkPrev_q <= linkClk;
         framePrev_q <= linkFrame;
         if (linkFrame && linkClk && !clkPrev_q)
         begin
            shift_q <= {shift_q[14:0], linkData};
            bits_q <= bits_q + 5'h01;
         end
         if (!linkFrame && framePrev_q)
         begin
            rxPacket <= shift_q;
            rxBits <= bits_q;
            rxCount <= rxCount + 1;
            bits_q <= 5'h00;
         end
      end
   end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Purpose: self-checking bench of the pll control bank
// Assumes: 200 MHz mclk
// Notes: table of reset reads, then hand-written cases
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed { logic [4:0] a; logic [23:0] e; } row_s;
   logic mclk, rst_n, regWrite, regRead, chipEnablePin, calPayloadWrite;
   logic vcoLinkClk, vcoLinkData, vcoLinkFrame, vcoLinkBusy, softReset, synthEnable;
   logic [4:0] regAddr, readPointer, rxBits;
   logic [23:0] regWdata, regRdata, configWord0A;
   logic [8:0] calPayload;
   pll_ctrl_pkg::power_domains_s powerOn;
   pll_ctrl_pkg::vco_packet_s rxPacket;
   int errors, compares, rxCount;
   row_s rows [5] = '{'{5'h00, 24'h5A5A01}, '{5'h01, 24'h000002}, '{5'h05, 24'h000000},
                      '{5'h02, 24'h000000}, '{5'h1F, 24'h000000}};
   pll_control_regs_vco_forwarder dut (.mclk(mclk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .readPointer(readPointer),
      .softReset(softReset), .configWord0A(configWord0A), .calPayloadWrite(calPayloadWrite),
      .calPayload(calPayload), .chipEnablePin(chipEnablePin), .synthEnable(synthEnable), .powerOn(powerOn),
      .vcoLinkClk(vcoLinkClk), .vcoLinkData(vcoLinkData), .vcoLinkFrame(vcoLinkFrame), .vcoLinkBusy(vcoLinkBusy));
   vco_link_receiver partner (.mclk(mclk), .rst_n(rst_n), .linkClk(vcoLinkClk), .linkData(vcoLinkData),
      .linkFrame(vcoLinkFrame), .rxPacket(rxPacket), .rxBits(rxBits), .rxCount(rxCount));
   always #2.5 mclk = ~mclk;
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // strobe stays up so back-to-back writes never assign it twice in a step
   task automatic wr(input logic [4:0] a, input logic [23:0] d);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
   endtask
   task automatic idle();
      regWrite <= 1'b0;
      @(negedge mclk);
   endtask
   task automatic rd(input logic [4:0] a, input logic [23:0] e);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      @(negedge mclk);
      chk(regRdata, e);
      @(posedge mclk);
   endtask
   task automatic waitRx(input int n);
      for (int k = 0; k < 3000 && rxCount < n; k++) @(posedge mclk);
      @(negedge mclk);
      chk(24'(rxCount), 24'(n));
      chk({19'h0, rxBits}, 24'h000010);
      @(posedge mclk);
   endtask
   task automatic end_sim();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #50000;
      errors++;
      end_sim();
   end
   initial
   begin
      {mclk, rst_n, regWrite, regRead, chipEnablePin, calPayloadWrite} = '0;
      {regAddr, regWdata, configWord0A, calPayload} = '0;
      errors = 0;
      compares = 0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      chk({18'h0, powerOn}, 24'h00003F);
      @(posedge mclk);
      foreach (rows[i]) rd(rows[i].a, rows[i].e);
      wr(5'h01, 24'hFFFFFE);
      wr(5'h02, 24'h000000);
      idle();
      @(posedge mclk);
      rd(5'h01, 24'h0003FE);
      for (int i = 2; i < 8; i++)
      begin
         wr(5'h01, 24'h000001 << i);
         idle();
         chk({17'h0, synthEnable, powerOn}, 24'h000020 >> (i - 2));
         @(posedge mclk);
      end
      wr(5'h01, 24'h000001);
      chipEnablePin <= 1'b1;
      idle();
      repeat (4) @(negedge mclk);
      chk({23'h0, synthEnable}, 24'h000001);
      @(posedge mclk);
      chipEnablePin <= 1'b0;
      repeat (4) @(negedge mclk);
      chk({23'h0, synthEnable}, 24'h000000);
      @(posedge mclk);
      wr(5'h00, 24'h000015);
      idle();
      chk({18'h0, readPointer, softReset}, 24'h00002A);
      @(posedge mclk);
      wr(5'h00, 24'h00002A);
      idle();
      chk({23'h0, softReset}, 24'h000001);
      @(negedge mclk);
      chk({18'h0, readPointer, softReset}, 24'h000000);
      @(posedge mclk);
      // start-up order: reference, modulator, charge pump, then the packets
      wr(5'h02, 24'h000001);
      wr(5'h06, 24'h000000);
      wr(5'h09, 24'h000000);
      // second packet queues, third overwrites it before launch
      wr(5'h05, 24'h00FE10);
      wr(5'h05, 24'h001230);
      wr(5'h05, 24'h00A580);
      idle();
      chk({23'h0, vcoLinkBusy}, 24'h000001);
      waitRx(1);
      chk({8'h00, rxPacket}, 24'h00FE10);
      waitRx(2);
      chk({8'h00, rxPacket}, 24'h00A580);
      rd(5'h05, 24'h00A580);
      configWord0A <= 24'h002000;
      wr(5'h05, 24'h003C00);
      idle();
      for (int k = 0; k < 50 && !vcoLinkFrame; k++) @(posedge mclk);
      configWord0A <= 24'h000000;
      waitRx(3);
      chk({8'h00, rxPacket}, 24'h003C00);
      calPayload <= 9'h155;
      calPayloadWrite <= 1'b1;
      @(posedge mclk);
      calPayloadWrite <= 1'b0;
      waitRx(4);
      chk({8'h00, rxPacket}, 24'h00AA80);
      rd(5'h05, 24'h00AA80);
      // retuning touches only the frequency words, so the link stays quiet
      wr(5'h03, 24'h000019);
      wr(5'h04, 24'h000000);
      idle();
      chk({23'h0, vcoLinkBusy}, 24'h000000);
      @(posedge mclk);
      wr(5'h00, 24'h000015);
      idle();
      // mid-run reset must restore the power word and clear the read pointer
      @(posedge mclk);
      rst_n <= 1'b0;
      @(negedge mclk);
      chk({12'h000, readPointer, vcoLinkBusy, powerOn}, 24'h00003F);
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rd(5'h01, 24'h000002);
      rd(5'h05, 24'h000000);
      end_sim();
   end
endmodule
`default_nettype wire
